// File: haptic_actuator_calibration_regs.sv
// Calibration and top configuration register group of the haptic driver
//
// Local design decision: the strobed register port.
`include "haptic_cal_params.svh"

// Function
// - Factor is high byte in bits 15..8 and low byte in 7..0.
// - Factor drives the voltage level; resets to high 0x01, low 0x0D.
// - Measured impedance is read-only, 8-bit high and 2-bit low, reset zero.
// - Policy bit 7 clear keeps faults for host; set clears them automatically.
// - Bit 5 selects actuator: 0 linear resonant, 1 rotating mass; reset 0.
// - Bit 4 enables internal loop computations, reset 1; 0 means custom waveform.
// - Bit 3 enables frequency tracking, reset 1; ignored for rotating mass.
// - Bit 2 enables active acceleration; reset 1.
// - Bit 1 enables rapid stop braking; reset 1.
// - Bit 0 enables amplitude loop; reset 0.
// - Peak current code is 5-bit read-write in bits 4..0, reset 0x17.
// - Acceleration selects absolute maximum as overdrive limit or full scale.
// - Automatic factor updates happen unless the freeze control or a host write to that byte in the same cycle blocks them.
module haptic_actuator_calibration_regs (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic playback_i,
  input wire logic factor_update_i,
  input wire logic [15:0] factor_update_value_i,
  input wire logic impedance_valid_i,
  input wire logic [9:0] impedance_i,
  input wire logic [7:0] abs_max_code_i,
  output logic [7:0] rdata_o,
  output logic [15:0] drive_translation_factor_o,
  output logic [4:0] peak_current_code_o,
  output haptic_cal_pkg::actuator_type_t actuator_type_o,
  output haptic_cal_pkg::fault_policy_t fault_policy_o,
  output logic loop_compute_en_o,
  output logic freq_track_en_o,
  output logic accel_en_o,
  output logic rapid_stop_en_o,
  output logic amplitude_loop_en_o,
  output logic [7:0] overdrive_limit_o,
  output logic [7:0] waveform_full_scale_o,
  output logic factor_updates_frozen_o
);
  import haptic_cal_pkg::*;

  logic [4:0] peak_current_code;
  logic [7:0] drive_factor_msb;
  logic [7:0] drive_factor_lsb;
  logic [7:0] top_feature_config;
  logic [1:0] factor_ctrl;
  logic [7:0] imp_high;
  logic [1:0] imp_low;
  logic [7:0] next_rdata;
  logic freeze_active;
  logic auto_update_ok;
  logic [15:0] drive_translation_factor;

  logic we_peak;
  logic we_high;
  logic we_low;
  logic we_cfg;
  logic we_ctrl;

  // One-hot write decode
  always_comb begin
    we_peak = 1'b0;
    we_high = 1'b0;
    we_low = 1'b0;
    we_cfg = 1'b0;
    we_ctrl = 1'b0;
    if (wr_i) begin
      case (addr_i)
        `ADDR_PEAK_CURRENT: we_peak = 1'b1;
        `ADDR_FACTOR_HIGH: we_high = 1'b1;
        `ADDR_FACTOR_LOW: we_low = 1'b1;
        `ADDR_TOP_CONFIG: we_cfg = 1'b1;
        `ADDR_FACTOR_CTRL: we_ctrl = 1'b1;
        default: begin
          // Read-only impedance and unmapped offsets take no write
        end
      endcase
    end
  end

  // Freeze blocks every automatic factor update; the playback freeze only while playing
  assign freeze_active = factor_ctrl[`CTRL_FREEZE] ||
    (factor_ctrl[`CTRL_PLAY_FREEZE] && playback_i);
  assign auto_update_ok = factor_update_i && !freeze_active;

  cal_byte_reg #(
    .WIDTH(5),
    .RESET_VALUE(`RST_PEAK_CURRENT)
  ) u_peak (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sw_we_i(we_peak),
    .sw_data_i(wdata_i[4:0]),
    .hw_we_i(1'b0),
    .hw_data_i(5'h00),
    .value_o(peak_current_code)
  );

  cal_byte_reg #(
    .WIDTH(8),
    .RESET_VALUE(`RST_FACTOR_HIGH)
  ) u_factor_high (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sw_we_i(we_high),
    .sw_data_i(wdata_i),
    .hw_we_i(auto_update_ok),
    .hw_data_i(factor_update_value_i[15:8]),
    .value_o(drive_factor_msb)
  );

  cal_byte_reg #(
    .WIDTH(8),
    .RESET_VALUE(`RST_FACTOR_LOW)
  ) u_factor_low (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sw_we_i(we_low),
    .sw_data_i(wdata_i),
    .hw_we_i(auto_update_ok),
    .hw_data_i(factor_update_value_i[7:0]),
    .value_o(drive_factor_lsb)
  );

  // Unassigned bit 6 is masked off so it always stores zero
  cal_byte_reg #(
    .WIDTH(8),
    .RESET_VALUE(`RST_TOP_CONFIG)
  ) u_top_config (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sw_we_i(we_cfg),
    .sw_data_i(wdata_i & `CFG_WRITABLE_MASK),
    .hw_we_i(1'b0),
    .hw_data_i(8'h00),
    .value_o(top_feature_config)
  );

  cal_byte_reg #(
    .WIDTH(2),
    .RESET_VALUE(`RST_FACTOR_CTRL)
  ) u_factor_ctrl (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sw_we_i(we_ctrl),
    .sw_data_i(wdata_i[1:0]),
    .hw_we_i(1'b0),
    .hw_data_i(2'h0),
    .value_o(factor_ctrl)
  );

  assign drive_translation_factor = {drive_factor_msb, drive_factor_lsb};

  // Measurement result loads from the engine only; host writes never reach it
  cal_byte_reg #(
    .WIDTH(8),
    .RESET_VALUE(`RST_IMP_HIGH)
  ) u_imp_high (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sw_we_i(1'b0),
    .sw_data_i(8'h00),
    .hw_we_i(impedance_valid_i),
    .hw_data_i(impedance_i[9:2]),
    .value_o(imp_high)
  );

  cal_byte_reg #(
    .WIDTH(2),
    .RESET_VALUE(`RST_IMP_LOW)
  ) u_imp_low (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sw_we_i(1'b0),
    .sw_data_i(2'h0),
    .hw_we_i(impedance_valid_i),
    .hw_data_i(impedance_i[1:0]),
    .value_o(imp_low)
  );

  always_comb begin
    next_rdata = 8'h00;
    if (rd_i) begin
      case (addr_i)
        `ADDR_PEAK_CURRENT: next_rdata = {3'h0, peak_current_code};
        `ADDR_FACTOR_HIGH: next_rdata = drive_factor_msb;
        `ADDR_FACTOR_LOW: next_rdata = drive_factor_lsb;
        `ADDR_IMP_HIGH: next_rdata = imp_high;
        `ADDR_IMP_LOW: next_rdata = {6'h00, imp_low};
        `ADDR_TOP_CONFIG: next_rdata = top_feature_config;
        `ADDR_FACTOR_CTRL: next_rdata = {6'h00, factor_ctrl};
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else begin
      rdata_o <= next_rdata;
    end
  end

  // Copies of the stored values; outputs trail the registers by one cycle
  logic [15:0] next_factor_o;
  logic [4:0] next_peak_code;

  always_comb begin
    next_factor_o = drive_translation_factor;
    next_peak_code = peak_current_code;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      drive_translation_factor_o <= {`RST_FACTOR_HIGH, `RST_FACTOR_LOW};
      peak_current_code_o <= `RST_PEAK_CURRENT;
    end else begin
      drive_translation_factor_o <= next_factor_o;
      peak_current_code_o <= next_peak_code;
    end
  end

  // Feature selects decoded from the top configuration byte
  fault_policy_t next_fault_policy;
  actuator_type_t next_actuator_type;
  logic next_loop_compute;
  logic next_freq_track;
  logic next_accel;
  logic next_rapid_stop;
  logic next_amp_loop;

  always_comb begin
    next_fault_policy = fault_policy_t'(top_feature_config[`CFG_AUTO_CLEAR]);
    next_actuator_type = actuator_type_t'(top_feature_config[`CFG_ACT_TYPE]);
    next_loop_compute = top_feature_config[`CFG_LOOP_COMPUTE];
    // Tracking has no meaning on a rotating mass motor
    next_freq_track = top_feature_config[`CFG_FREQ_TRACK] &&
      !top_feature_config[`CFG_ACT_TYPE];
    next_accel = top_feature_config[`CFG_ACCEL];
    next_rapid_stop = top_feature_config[`CFG_RAPID_STOP];
    next_amp_loop = top_feature_config[`CFG_AMP_LOOP];
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      fault_policy_o <= FAULT_HOST_CLEAR;
      actuator_type_o <= ACT_LINEAR_RESONANT;
      loop_compute_en_o <= 1'b1;
      freq_track_en_o <= 1'b1;
      accel_en_o <= 1'b1;
      rapid_stop_en_o <= 1'b1;
      amplitude_loop_en_o <= 1'b0;
    end else begin
      fault_policy_o <= next_fault_policy;
      actuator_type_o <= next_actuator_type;
      loop_compute_en_o <= next_loop_compute;
      freq_track_en_o <= next_freq_track;
      accel_en_o <= next_accel;
      rapid_stop_en_o <= next_rapid_stop;
      amplitude_loop_en_o <= next_amp_loop;
    end
  end

  // Absolute maximum code takes one role at a time; the idle role shows zero
  logic [7:0] next_overdrive;
  logic [7:0] next_full_scale;

  always_comb begin
    if (top_feature_config[`CFG_ACCEL]) begin
      next_overdrive = abs_max_code_i;
      next_full_scale = 8'h00;
    end else begin
      next_overdrive = 8'h00;
      next_full_scale = abs_max_code_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      overdrive_limit_o <= 8'h00;
      waveform_full_scale_o <= 8'h00;
    end else begin
      overdrive_limit_o <= next_overdrive;
      waveform_full_scale_o <= next_full_scale;
    end
  end

  logic next_frozen;

  always_comb begin
    next_frozen = freeze_active;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      factor_updates_frozen_o <= 1'b0;
    end else begin
      factor_updates_frozen_o <= next_frozen;
    end
  end
endmodule : haptic_actuator_calibration_regs

// File: haptic_cal_params.svh
// Register offsets, field positions and reset values of the calibration register group
`ifndef HAPTIC_CAL_PARAMS_SVH
`define HAPTIC_CAL_PARAMS_SVH

`define ADDR_PEAK_CURRENT 8'h0E
`define ADDR_FACTOR_HIGH 8'h0F
`define ADDR_FACTOR_LOW 8'h10
`define ADDR_IMP_HIGH 8'h11
`define ADDR_IMP_LOW 8'h12
`define ADDR_TOP_CONFIG 8'h13
`define ADDR_FACTOR_CTRL 8'h40

`define RST_PEAK_CURRENT 5'h17
`define RST_FACTOR_HIGH 8'h01
`define RST_FACTOR_LOW 8'h0D
`define RST_IMP_HIGH 8'h00
`define RST_IMP_LOW 2'h0
`define RST_TOP_CONFIG 8'h1E
`define RST_FACTOR_CTRL 2'h2

`define CFG_AUTO_CLEAR 7
`define CFG_ACT_TYPE 5
`define CFG_LOOP_COMPUTE 4
`define CFG_FREQ_TRACK 3
`define CFG_ACCEL 2
`define CFG_RAPID_STOP 1
`define CFG_AMP_LOOP 0
`define CFG_WRITABLE_MASK 8'hBF

`define CTRL_FREEZE 0
`define CTRL_PLAY_FREEZE 1

`endif

// File: haptic_cal_pkg.sv
// Types shared by the calibration register group
package haptic_cal_pkg;
  typedef enum logic {
    ACT_LINEAR_RESONANT,
    ACT_ROTATING_MASS
  } actuator_type_t;

  typedef enum logic {
    FAULT_HOST_CLEAR,
    FAULT_AUTO_CLEAR
  } fault_policy_t;
endpackage : haptic_cal_pkg

// File: cal_byte_reg.sv
// One register of WIDTH bits with host write port, hardware load port and reset value
module cal_byte_reg #(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sw_we_i,
  input wire logic [WIDTH-1:0] sw_data_i,
  input wire logic hw_we_i,
  input wire logic [WIDTH-1:0] hw_data_i,
  output logic [WIDTH-1:0] value_o
);
  logic [WIDTH-1:0] next_value;

  // Host write takes precedence over an automatic update in the same cycle
  always_comb begin
    next_value = value_o;
    if (sw_we_i) begin
      next_value = sw_data_i;
    end else if (hw_we_i) begin
      next_value = hw_data_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      value_o <= RESET_VALUE;
    end else begin
      value_o <= next_value;
    end
  end
endmodule : cal_byte_reg

// File: cal_regs_properties.sv
// Port assertions for the calibration register group
module cal_regs_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] abs_max_code_i,
  input wire logic [7:0] rdata_o,
  input wire logic [15:0] drive_translation_factor_o,
  input wire logic [4:0] peak_current_code_o,
  input wire haptic_cal_pkg::actuator_type_t actuator_type_o,
  input wire haptic_cal_pkg::fault_policy_t fault_policy_o,
  input wire logic loop_compute_en_o,
  input wire logic freq_track_en_o,
  input wire logic accel_en_o,
  input wire logic rapid_stop_en_o,
  input wire logic amplitude_loop_en_o,
  input wire logic [7:0] overdrive_limit_o,
  input wire logic [7:0] waveform_full_scale_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import haptic_cal_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  factor_high_a: assert property (
    wr_i && addr_i == 8'h0F |-> ##2 drive_translation_factor_o[15:8] == $past(wdata_i, 2))
    else $error("factor high byte wrong");
  factor_low_a: assert property (
    wr_i && addr_i == 8'h10 |-> ##2 drive_translation_factor_o[7:0] == $past(wdata_i, 2))
    else $error("factor low byte wrong");
  peak_code_a: assert property (
    wr_i && addr_i == 8'h0E |-> ##2 peak_current_code_o == $past(wdata_i[4:0], 2))
    else $error("peak code wrong");
  cfg_mode_a: assert property (wr_i && addr_i == 8'h13 |-> ##2
    fault_policy_o == $past(wdata_i[7], 2) && actuator_type_o == $past(wdata_i[5], 2))
    else $error("policy or type wrong");
  cfg_enables_a: assert property (wr_i && addr_i == 8'h13 |-> ##2
    {loop_compute_en_o, accel_en_o, rapid_stop_en_o, amplitude_loop_en_o}
    == {$past(wdata_i[4], 2), $past(wdata_i[2:0], 2)})
    else $error("enable bits wrong");
  track_gate_a: assert property (
    freq_track_en_o |-> actuator_type_o == ACT_LINEAR_RESONANT)
    else $error("tracking on for rotating mass");
  imp_low_a: assert property (
    rd_i && addr_i == 8'h12 |=> rdata_o[7:2] == 6'h00)
    else $error("impedance low spare bits set");
  overdrive_a: assert property (accel_en_o && !$past(rst_i) |->
    overdrive_limit_o == $past(abs_max_code_i) && waveform_full_scale_o == 8'h00)
    else $error("overdrive limit wrong");
  full_scale_a: assert property (!accel_en_o && !$past(rst_i) |->
    waveform_full_scale_o == $past(abs_max_code_i) && overdrive_limit_o == 8'h00)
    else $error("full scale wrong");
  cover property (wr_i && addr_i == 8'h13);
  cover property (!accel_en_o);
  cover property (rd_i && addr_i == 8'h12);
endmodule : cal_regs_checker

bind haptic_actuator_calibration_regs cal_regs_checker i_chk (.clk_i, .rst_i, .addr_i,
  .wdata_i, .wr_i, .rd_i, .abs_max_code_i, .rdata_o, .drive_translation_factor_o,
  .peak_current_code_o, .actuator_type_o, .fault_policy_o, .loop_compute_en_o,
  .freq_track_en_o, .accel_en_o, .rapid_stop_en_o, .amplitude_loop_en_o,
  .overdrive_limit_o, .waveform_full_scale_o);

// File: host_model.sv
// Host controller model on the register port
module host_model (
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o,
  output logic wr_o,
  output logic rd_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    addr_o = 8'h00;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= v;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
  endtask : wr
  // Data stands only in the cycle after the strobe, so sample mid-cycle
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    @(negedge clk_i);
    d = rdata_i;
  endtask : rd
endmodule : host_model

// File: testbench.sv
// Self-checking bench for the calibration register group
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import haptic_cal_pkg::*;
  logic clk = 0, rst = 1, wr, rd, play = 0, fupd = 0, ivld = 0;
  logic lce, fte, acc, rse, ale, frz;
  logic [7:0] addr, wdata, rdata, d, ovd, wfs, absm = 8'h78;
  logic [15:0] fval = 16'h0000, fac;
  logic [9:0] imp = 10'h000;
  logic [4:0] pk;
  actuator_type_t atype;
  fault_policy_t fpol;
  int n_mismatch = 0, checks = 0;
  always #25 clk = ~clk;
  host_model i_host (.clk_i(clk), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
    .wr_o(wr), .rd_o(rd));
  haptic_actuator_calibration_regs i_dut (.clk_i(clk), .rst_i(rst), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .playback_i(play), .factor_update_i(fupd),
    .factor_update_value_i(fval), .impedance_valid_i(ivld), .impedance_i(imp),
    .abs_max_code_i(absm), .rdata_o(rdata), .drive_translation_factor_o(fac),
    .peak_current_code_o(pk), .actuator_type_o(atype), .fault_policy_o(fpol),
    .loop_compute_en_o(lce), .freq_track_en_o(fte), .accel_en_o(acc),
    .rapid_stop_en_o(rse), .amplitude_loop_en_o(ale), .overdrive_limit_o(ovd),
    .waveform_full_scale_o(wfs), .factor_updates_frozen_o(frz));
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    i_host.rd(a, d);
    chk(d, e);
  endtask : rchk
  task automatic settle();
    @(posedge clk);
    @(negedge clk);
  endtask : settle
  // Playback level leads the request by a cycle so the freeze is in place
  task automatic upd(input logic [15:0] v, input logic p);
    @(posedge clk);
    play <= p;
    @(posedge clk);
    fupd <= 1'b1;
    fval <= v;
    @(posedge clk);
    fupd <= 1'b0;
    settle();
  endtask : upd
  task automatic t_reset();
    logic [7:0] a[7] = '{8'h0E, 8'h0F, 8'h10, 8'h11, 8'h12, 8'h13, 8'h40};
    logic [7:0] e[7] = '{8'h17, 8'h01, 8'h0D, 8'h00, 8'h00, 8'h1E, 8'h02};
    chk(fac, 16'h010D);
    foreach (a[i]) rchk(a[i], e[i]);
    rchk(8'h55, 8'h00);
  endtask : t_reset
  task automatic t_factor();
    // 22 ohm at code 0x17 gives 369
    i_host.wr(8'h0F, 8'h01);
    i_host.wr(8'h10, 8'h71);
    settle();
    chk(fac, 16'h0171);
    rchk(8'h10, 8'h71);
    upd(16'hBEEF, 1'b0);
    chk(fac, 16'hBEEF);
    upd(16'h1234, 1'b1);
    chk({frz, fac}, {1'b1, 16'hBEEF});
    i_host.wr(8'h40, 8'h01);
    upd(16'h5A5A, 1'b0);
    chk({frz, fac}, {1'b1, 16'hBEEF});
    i_host.wr(8'h40, 8'h00);
    upd(16'h1234, 1'b1);
    chk({frz, fac}, {1'b0, 16'h1234});
  endtask : t_factor
  task automatic t_imp();
    @(posedge clk);
    ivld <= 1'b1;
    imp <= 10'h15B;
    @(posedge clk);
    ivld <= 1'b0;
    i_host.wr(8'h11, 8'hFF);
    i_host.wr(8'h12, 8'hFF);
    rchk(8'h11, 8'h56);
    rchk(8'h12, 8'h03);
  endtask : t_imp
  task automatic t_cfg();
    i_host.wr(8'h13, 8'hFF);
    rchk(8'h13, 8'hBF);
    chk({fte, acc, rse, lce, ale, ovd, wfs}, {5'b01111, absm, 8'h00});
    chk({atype, fpol}, 2'b11);
    i_host.wr(8'h13, 8'h08);
    i_host.wr(8'h0E, 8'hFF);
    settle();
    chk({fte, acc, rse, lce, ale, wfs, ovd}, {5'b10000, absm, 8'h00});
    chk(pk, 5'h1F);
  endtask : t_cfg
  // Reset in mid-run must bring every register back from non-default values
  task automatic t_midreset();
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    t_reset();
  endtask : t_midreset
  task automatic give_verdict();
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_factor();
    t_imp();
    t_cfg();
    t_midreset();
    give_verdict();
  end
  initial begin
    #100000;
    n_mismatch++;
    give_verdict();
  end
endmodule : testbench
